// ### hw/vsc_step_controller.sv
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Control word mode bit picks two-state hysteresis or three-state pulse control.
// - Two-state: demand above 55 percent opens and releases close.
// - Two-state: demand below 45 percent closes and releases open.
// - Two-state: demand within 45..55 percent keeps both outputs as before.
// - Open drives valve towards open; close drives it towards closed.
// - Three-state: minimum pulse width counts 0.1 s ticks; only a drop of enable or a clear of the mode bit cuts a pulse shorter.
// - Three-state: drive follows sign and rate of demand change, else idle.
// - Three-state: drive time equals change fraction of full stroke, in pulses.
// - Three-state: constant demand slope keeps constant pulse repetition.
// - Control word bits 15..8 are settings, bits 7..0 status.
// - Bit 0 mirrors enable input, bit 1 mirrors enable-out.
// - Bit 2 reads one while open is active.
// - Bit 3 reads one while close is active.
// - Bit 7 holds enable from the previous execution.
module vsc_step_controller #(
   parameter int EXEC_CYCLES = vsc_pkg::EXEC_CYCLES,
   parameter int TICK_CYCLES = vsc_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Block enable
   input  wire logic        ENABLE,
   output logic             ENABLE_OUT,
   // Valve drive
   output logic             VALVE_OPEN,
   output logic             VALVE_CLOSE
);

   // Elaboration checks on the divider parameters.
   // A tick must be a whole number of executions. Otherwise a pulse could
   // end between two evaluations and the drive would stay on until the next one.
   if (EXEC_CYCLES < 1) begin : g_bad_exec
      $error("vsc_step_controller: execution period below one cycle");
   end
   if (TICK_CYCLES < EXEC_CYCLES) begin : g_bad_tick
      $error("vsc_step_controller: tick shorter than execution period");
   end
   if (EXEC_CYCLES > 0 && (TICK_CYCLES % EXEC_CYCLES) != 0) begin : g_bad_ratio
      $error("vsc_step_controller: tick not a multiple of execution period");
   end

   // Registers
   logic [7:0]          settings_ff;
   logic [15:0]         demand_ff;
   logic [15:0]         min_pulse_ff;
   logic [15:0]         full_stroke_ff;
   logic [15:0]         prev_demand_ff;
   logic signed [31:0]  remainder_ff;
   logic [15:0]         hold_ff;
   logic [31:0]         exec_cnt_ff;
   logic [31:0]         tick_cnt_ff;
   logic                prev_en_ff;
   logic                open_ff;
   logic                close_ff;
   logic                eno_ff;
   logic [31:0]         prdata_ff;
   logic                pslverr_ff;
   vsc_pkg::vsc_drive_t drive_ff;

   // Execution and tick strobes from one clock
   wire exec_stb = (exec_cnt_ff == 32'(EXEC_CYCLES - 1));
   wire tick_stb = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

   // APB decode; slave answers in the access cycle
   wire access   = PSEL & PENABLE;
   wire wr_en    = access & PWRITE;
   wire sel_cw   = (PADDR == vsc_pkg::ADDR_CONTROL_WORD);
   wire sel_dem  = (PADDR == vsc_pkg::ADDR_DEMAND);
   wire sel_minp = (PADDR == vsc_pkg::ADDR_MIN_PULSE);
   wire sel_full = (PADDR == vsc_pkg::ADDR_FULL_STROKE);
   wire sel_st   = (PADDR == vsc_pkg::ADDR_STATE);
   wire mapped   = sel_cw | sel_dem | sel_minp | sel_full | sel_st;

   // Control word view: settings high, status low
   wire [15:0] control_word = {settings_ff,
                               prev_en_ff, 3'h0,
                               close_ff, open_ff,
                               eno_ff, ENABLE};
   wire three_state = settings_ff[vsc_pkg::CW_MODE_BIT - 8];

   // Read data mux
   wire [31:0] rd_mux =
      sel_cw   ? {16'h0000, control_word} :
      sel_dem  ? {16'h0000, demand_ff} :
      sel_minp ? {16'h0000, min_pulse_ff} :
      sel_full ? {16'h0000, full_stroke_ff} :
      sel_st   ? {hold_ff, prev_demand_ff} : 32'h00000000;

   // Demand clamped to full scale
   wire [15:0] demand_c = (demand_ff > vsc_pkg::DEMAND_FULL) ?
                          vsc_pkg::DEMAND_FULL : demand_ff;

   // Drive ticks owed for a demand step: step/full * stroke(s) * 10
   wire signed [31:0] step_val = $signed({16'h0000, demand_c}) -
                                 $signed({16'h0000, prev_demand_ff});
   wire signed [47:0] owed_w   = (48'(step_val) * $signed({32'h0, full_stroke_ff}) *
                                  48'sd10) / $signed({32'h0, vsc_pkg::DEMAND_FULL});
   wire signed [31:0] owed     = owed_w[31:0];
   wire signed [31:0] rem_sum  = remainder_ff + owed;

   // Zero width would pulse on every evaluation, so it counts as one tick.
   // The start threshold uses the same width that a pulse then runs.
   wire [15:0] min_eff = (min_pulse_ff == 16'h0000) ? 16'h0001 : min_pulse_ff;
   wire signed [31:0] minw     = $signed({16'h0000, min_eff});

   // Hysteresis decisions
   wire hi_dem = demand_c > vsc_pkg::DEMAND_HI;
   wire lo_dem = demand_c < vsc_pkg::DEMAND_LO;

   // Three-state pulse scheduling: start when a pulse-width is owed
   wire pulse_busy = (hold_ff != 16'h0000);
   wire start_open  = !pulse_busy && (rem_sum >= minw);
   wire start_close = !pulse_busy && (rem_sum <= -minw);

   // A pulse starts at an evaluation. The tick divider restarts with it,
   // so the first tick of the pulse is a whole 0.1 s and no pulse runs
   // short of its minimum width.
   wire pulse_start = exec_stb && ENABLE && three_state &&
                      (drive_ff == vsc_pkg::VSC_IDLE) &&
                      (start_open || start_close);

   // Next values for the drive state
   logic nxt_open;
   logic nxt_close;
   logic signed [31:0] nxt_rem;
   logic [15:0] nxt_hold;
   vsc_pkg::vsc_drive_t nxt_drive;
   always_comb begin
      nxt_open  = open_ff;
      nxt_close = close_ff;
      nxt_rem   = remainder_ff;
      nxt_hold  = hold_ff;
      nxt_drive = drive_ff;
      if (!ENABLE) begin
         nxt_open  = 1'b0;
         nxt_close = 1'b0;
         nxt_rem   = 32'sd0;
         nxt_hold  = 16'h0000;
         nxt_drive = vsc_pkg::VSC_IDLE;
      end else if (!three_state) begin
         if (hi_dem) begin
            nxt_open  = 1'b1;
            nxt_close = 1'b0;
         end else if (lo_dem) begin
            nxt_close = 1'b1;
            nxt_open  = 1'b0;
         end
         nxt_rem   = 32'sd0;
         nxt_hold  = 16'h0000;
         nxt_drive = vsc_pkg::VSC_IDLE;
      end else begin
         nxt_rem = rem_sum;
         // Hold counts down in ticks; a started pulse runs its full width
         if (pulse_busy && tick_stb) begin
            nxt_hold = hold_ff - 16'h0001;
         end
         unique case (drive_ff)
            vsc_pkg::VSC_IDLE: begin
               if (start_open) begin
                  nxt_drive = vsc_pkg::VSC_OPEN;
                  nxt_hold  = min_eff;
                  nxt_rem   = rem_sum - $signed({16'h0000, min_eff});
               end else if (start_close) begin
                  nxt_drive = vsc_pkg::VSC_CLOSE;
                  nxt_hold  = min_eff;
                  nxt_rem   = rem_sum + $signed({16'h0000, min_eff});
               end
            end
            vsc_pkg::VSC_OPEN, vsc_pkg::VSC_CLOSE: begin
               // Back to idle after the last tick, so a steady slope repeats
               // A hold already at zero ends the pulse too, so the drive
               // can never be left on with nothing counting it down.
               if (!pulse_busy || (hold_ff == 16'h0001 && tick_stb)) begin
                  nxt_drive = vsc_pkg::VSC_IDLE;
               end
            end
            default: nxt_drive = vsc_pkg::VSC_IDLE;
         endcase
         nxt_open  = (nxt_drive == vsc_pkg::VSC_OPEN);
         nxt_close = (nxt_drive == vsc_pkg::VSC_CLOSE);
      end
   end

   // Free-running execution divider; the tick divider also restarts on a pulse start
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         exec_cnt_ff <= 32'h00000000;
         tick_cnt_ff <= 32'h00000000;
      end else begin
         exec_cnt_ff <= exec_stb ? 32'h00000000 : exec_cnt_ff + 32'h00000001;
         // Restart on a pulse start keeps ticks aligned to the pulse
         tick_cnt_ff <= (tick_stb || pulse_start) ? 32'h00000000 :
                        tick_cnt_ff + 32'h00000001;
      end
   end

   // Software-written settings
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         settings_ff    <= vsc_pkg::CW_SETTINGS_RST;
         demand_ff      <= 16'h0000;
         min_pulse_ff   <= vsc_pkg::MIN_PULSE_RST;
         full_stroke_ff <= vsc_pkg::FULL_STROKE_RST;
      end else if (wr_en) begin
         // Status bits of the control word are read-only
         if (sel_cw)   settings_ff    <= PWDATA[15:8];
         if (sel_dem)  demand_ff      <= PWDATA[15:0];
         if (sel_minp) min_pulse_ff   <= PWDATA[15:0];
         if (sel_full) full_stroke_ff <= PWDATA[15:0];
      end
   end

   // Block state updated once per execution; the hold also shortens on ticks in between
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         open_ff        <= 1'b0;
         close_ff       <= 1'b0;
         eno_ff         <= 1'b0;
         prev_en_ff     <= 1'b0;
         prev_demand_ff <= 16'h0000;
         remainder_ff   <= 32'sd0;
         hold_ff        <= 16'h0000;
         drive_ff       <= vsc_pkg::VSC_IDLE;
      end else if (exec_stb) begin
         open_ff        <= nxt_open;
         close_ff       <= nxt_close;
         eno_ff         <= ENABLE;
         prev_en_ff     <= ENABLE;
         prev_demand_ff <= demand_c;
         remainder_ff   <= nxt_rem;
         hold_ff        <= nxt_hold;
         drive_ff       <= nxt_drive;
      end else if (tick_stb && pulse_busy && three_state && ENABLE) begin
         // Ticks between executions still shorten the hold
         hold_ff <= hold_ff - 16'h0001;
      end
   end

   // APB read data register
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         prdata_ff <= 32'h00000000;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         prdata_ff <= rd_mux;
      end
   end

   // APB error flag, taken in the setup cycle like the read data.
   // Registering it keeps the pin glitch-free and lets it stand
   // through the single access cycle of a zero-wait transfer.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         pslverr_ff <= 1'b0;
      end else begin
         pslverr_ff <= PSEL & ~PENABLE & ~mapped;
      end
   end

   // Outputs straight from their registers; PREADY is tied high
   assign PRDATA      = prdata_ff;
   assign PREADY      = 1'b1;
   assign PSLVERR     = pslverr_ff;
   assign ENABLE_OUT  = eno_ff;
   assign VALVE_OPEN  = open_ff;
   assign VALVE_CLOSE = close_ff;

endmodule
`default_nettype wire

// ### hw/vsc_pkg.sv
package vsc_pkg;
   // Register map (byte addresses)
   localparam logic [11:0] ADDR_CONTROL_WORD = 12'h000;
   localparam logic [11:0] ADDR_DEMAND       = 12'h004;
   localparam logic [11:0] ADDR_MIN_PULSE    = 12'h008;
   localparam logic [11:0] ADDR_FULL_STROKE  = 12'h00c;
   localparam logic [11:0] ADDR_STATE        = 12'h010;

   // Control word fields
   localparam int CW_EN_BIT      = 0;
   localparam int CW_ENO_BIT     = 1;
   localparam int CW_OPEN_BIT    = 2;
   localparam int CW_CLOSE_BIT   = 3;
   localparam int CW_PREV_EN_BIT = 7;
   localparam int CW_MODE_BIT    = 8;
   localparam logic [7:0] CW_SETTINGS_RST = 8'h00;

   // Demand scale: percent times 100, 0..10000
   localparam logic [15:0] DEMAND_FULL = 16'h2710;
   localparam logic [15:0] DEMAND_HI   = 16'h157c; // 55.00 %
   localparam logic [15:0] DEMAND_LO   = 16'h1194; // 45.00 %

   // Timing: one tick is 0.1 s
   localparam int  CLK_HZ       = 10_000_000;
   localparam real TICK_S       = 0.1;
   localparam int  TICK_CYCLES  = int'(CLK_HZ * TICK_S);
   localparam int  EXEC_CYCLES  = 100;

   // Reset values
   localparam logic [15:0] MIN_PULSE_RST   = 16'h000a;
   localparam logic [15:0] FULL_STROKE_RST = 16'h0258;

   typedef enum logic [1:0] {VSC_IDLE, VSC_OPEN, VSC_CLOSE} vsc_drive_t;
endpackage

// ### dv/vsc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module vsc_checker (
   // Clock and reset
   input wire logic        CLK_SYS,
   input wire logic        RST_N,
   // Register bus
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic        PSLVERR,
   // Enable and drive
   input wire logic        ENABLE,
   input wire logic        ENABLE_OUT,
   input wire logic        VALVE_OPEN,
   input wire logic        VALVE_CLOSE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   // Five low cycles span one evaluation only while EXEC_CYCLES is 4 or less
   sequence s_off; !ENABLE [*5]; endsequence
   sequence s_rd_hole; PSEL && PENABLE && !PWRITE && PADDR > 12'h010; endsequence
   property p_excl; !(VALVE_OPEN && VALVE_CLOSE); endproperty
   property p_off; s_off |-> !ENABLE_OUT && !VALVE_OPEN && !VALVE_CLOSE; endproperty
   property p_eno; $changed(ENABLE_OUT) |-> ENABLE_OUT == $past(ENABLE); endproperty
   property p_op_en; $rose(VALVE_OPEN) |-> ENABLE_OUT; endproperty
   property p_cl_en; $rose(VALVE_CLOSE) |-> ENABLE_OUT; endproperty
   property p_op_hold; $changed(VALVE_OPEN) |=> $stable(VALVE_OPEN) [*3]; endproperty
   property p_cl_hold; $changed(VALVE_CLOSE) |=> $stable(VALVE_CLOSE) [*3]; endproperty
   property p_hole; s_rd_hole |-> PSLVERR && PRDATA == 32'h0; endproperty
   a_excl: assert property (p_excl) else $error("open and close together");
   a_off: assert property (p_off) else $error("drive while disabled");
   a_eno: assert property (p_eno) else $error("enable out mismatch");
   a_op_en: assert property (p_op_en) else $error("open without enable");
   a_cl_en: assert property (p_cl_en) else $error("close without enable");
   a_op_hold: assert property (p_op_hold) else $error("open off evaluation");
   a_cl_hold: assert property (p_cl_hold) else $error("close off evaluation");
   a_hole: assert property (p_hole) else $error("unmapped read answered");
endmodule
bind vsc_step_controller vsc_checker chk_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
   .ENABLE(ENABLE), .ENABLE_OUT(ENABLE_OUT), .VALVE_OPEN(VALVE_OPEN),
   .VALVE_CLOSE(VALVE_CLOSE));
`default_nettype wire

// ### dv/vsc_valve_model.sv
`timescale 1ns/1ps
`default_nettype none
module vsc_valve_model (
   // Motor drive
   input wire logic clk_sys,
   input wire logic open_cmd,
   input wire logic close_cmd,
   // Travel in cycles of motor run, fault flag
   output var int   travel,
   output var logic clash
);
   initial travel = 0;
   initial clash = 1'b0;
   // No end stops: net run time is what the bench needs
   always @(posedge clk_sys) begin
      if (open_cmd)
         travel <= travel + 1;
      if (close_cmd)
         travel <= travel - 1;
      if (open_cmd && close_cmd)
         clash <= 1'b1;
   end
endmodule
`default_nettype wire

// ### dv/valve_step_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
module valve_step_controller_bench;
   typedef struct {logic [15:0] dem; logic op; logic cl;} vsc_row_t;
   // Hold rows sit between the switching rows
   vsc_row_t    rows [6] = '{'{16'h157d, 1, 0}, '{16'h1388, 1, 0}, '{16'h1193, 0, 1},
                             '{16'h1194, 0, 1}, '{16'h157c, 0, 1}, '{16'h2710, 1, 0}};
   logic        clk_sys = 1'b0, rst_n = 1'b0, enable = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic        pready, pslverr, rerr, enable_out, v_open, v_close, clash;
   int          err_count = 0, tests_run = 0, cycles = 0, travel, t0;
   always #50 clk_sys = ~clk_sys;
   vsc_step_controller #(.EXEC_CYCLES(4), .TICK_CYCLES(40)) dut_u (.CLK_SYS(clk_sys),
      .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ENABLE(enable),
      .ENABLE_OUT(enable_out), .VALVE_OPEN(v_open), .VALVE_CLOSE(v_close));
   vsc_valve_model act_u (.clk_sys(clk_sys), .open_cmd(v_open), .close_cmd(v_close),
      .travel(travel), .clash(clash));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Tolerance covers evaluation granularity of the pulse train
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, int tol);
      tests_run++;
      if (tol == 0 ? g !== e : (g > e + tol || g + tol < e)) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(0, vsc_pkg::ADDR_MIN_PULSE, 0);
      chk("min pulse", 32'h000a, rdata, 0);
      apb(0, vsc_pkg::ADDR_FULL_STROKE, 0);
      chk("stroke", 32'h0258, rdata, 0);
      enable <= 1'b1;
      foreach (rows[i]) begin
         apb(1, vsc_pkg::ADDR_DEMAND, {16'h0, rows[i].dem});
         repeat (12) @(posedge clk_sys);
         apb(0, vsc_pkg::ADDR_CONTROL_WORD, 0);
         chk("cw", {24'h0, 4'h8, rows[i].cl, rows[i].op, 2'b11}, rdata, 0);
         chk("open", {31'h0, rows[i].op}, {31'h0, v_open}, 0);
         chk("close", {31'h0, rows[i].cl}, {31'h0, v_close}, 0);
      end
      // Status byte is not writable
      apb(1, vsc_pkg::ADDR_CONTROL_WORD, 32'h00ff);
      apb(0, vsc_pkg::ADDR_CONTROL_WORD, 0);
      chk("cw status", 32'h0087, rdata, 0);
      apb(0, 12'h014, 0);
      chk("hole err", 32'h1, {31'h0, rerr}, 0);
      enable <= 1'b0;
      repeat (12) @(posedge clk_sys);
      apb(0, vsc_pkg::ADDR_CONTROL_WORD, 0);
      chk("cw off", 32'h0000, rdata, 0);
      chk("drive off", 32'h0, {30'h0, v_open, v_close}, 0);
      // Three-state: 10 s stroke, 2-tick pulses
      enable <= 1'b1;
      apb(1, vsc_pkg::ADDR_MIN_PULSE, 32'h2);
      apb(1, vsc_pkg::ADDR_FULL_STROKE, 32'ha);
      apb(1, vsc_pkg::ADDR_CONTROL_WORD, 32'h0100);
      apb(1, vsc_pkg::ADDR_DEMAND, 32'h1388);
      repeat (3000) @(posedge clk_sys);
      t0 = travel;
      apb(1, vsc_pkg::ADDR_DEMAND, 32'h1b58);
      repeat (2000) @(posedge clk_sys);
      chk("open run", 32'd800, travel - t0, 40);
      t0 = travel;
      apb(1, vsc_pkg::ADDR_DEMAND, 32'h1770);
      repeat (2000) @(posedge clk_sys);
      chk("close run", 32'd400, t0 - travel, 40);
      chk("clash", 32'h0, {31'h0, clash}, 0);
      apb(0, vsc_pkg::ADDR_STATE, 0);
      chk("state", 32'h00001770, rdata, 0);
      wrap_up();
   end
endmodule
`default_nettype wire
